/* File: spm_pkg.sv */
/*
  spm_pkg: shared constants, types and timing figures for the panel signal monitor.
  assumes one 250 MHz clock and a panel of eight seven-segment digits with decimal points.
*/
package spm_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SPM_CLK_PERIOD_PS = 4000;
  localparam longint SPM_DEBOUNCE_NS = 10000000;
  localparam int SPM_DEBOUNCE_CYC = int'((SPM_DEBOUNCE_NS * 1000) / SPM_CLK_PERIOD_PS);
  localparam int SPM_DEB_W = 22;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int SPM_AXES = 2;
  localparam int SPM_DIGITS = 8;
  localparam int SPM_IN_TERMS = 8;
  localparam int SPM_OUT_TERMS = 6;
  localparam int SPM_KEYS = 4;
  localparam int SPM_CNT_W = 32;
  localparam int SPM_ITEM_W = 5;

  // ----------------------------------------
  // monitor item numbers
  // ----------------------------------------
  localparam logic [4:0] SPM_ITEM_SPEED = 5'h00;
  localparam logic [4:0] SPM_ITEM_IN = 5'h07;
  localparam logic [4:0] SPM_ITEM_OUT = 5'h08;
  localparam logic [4:0] SPM_ITEM_ENC = 5'h09;
  localparam logic [4:0] SPM_ITEM_CMD_CNT = 5'h0a;
  localparam logic [4:0] SPM_ITEM_MAX = 5'h10;
  localparam logic [4:0] SPM_ITEM_TEN = 5'h0a;

  // ----------------------------------------
  // counter pages
  // ----------------------------------------
  localparam logic [1:0] SPM_PAGE_LOW = 2'h0;
  localparam logic [1:0] SPM_PAGE_MID = 2'h1;
  localparam logic [1:0] SPM_PAGE_TOP = 2'h2;
  localparam int SPM_PAGE_LOW_LSB = 0;
  localparam int SPM_PAGE_MID_LSB = 16;
  localparam int SPM_PAGE_TOP_LSB = 32;
  localparam int SPM_TOP_DIGITS = 2;
  localparam int SPM_PAGE_DIGITS = 4;

  // ----------------------------------------
  // segment layout: [7]=dp [6]=g .. [0]=a
  // ----------------------------------------
  localparam int SPM_SEG_UPPER = 0;
  localparam int SPM_SEG_LOWER = 3;
  localparam int SPM_SEG_DP = 7;
  localparam logic [7:0] SPM_SEG_BLANK = 8'h00;
  localparam logic [7:0] SPM_SEG_DASH = 8'h40;
  localparam logic [7:0] SPM_SEG_U = 8'h3e;
  localparam logic [7:0] SPM_SEG_N = 8'h54;
  localparam int SPM_DIG_AXIS = 0;
  localparam int SPM_DIG_N = 3;
  localparam int SPM_DIG_U = 4;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic pos_mode;
    logic cmd_pulse;
    logic incr_enc;
    logic abc_brk;
    logic enc_phase_a;
    logic enc_phase_b;
    logic enc_phase_c;
    logic uvw_brk;
    logic enc_phase_u;
    logic enc_phase_v;
    logic enc_phase_w;
    logic [SPM_OUT_TERMS-1:0] out_on;
    logic [SPM_IN_TERMS-1:0] in_level;
  } spm_axis_t;

  typedef struct packed {
    logic shift;
    logic set;
    logic down;
    logic up;
  } spm_keys_t;

  typedef logic [SPM_DIGITS-1:0][7:0] spm_disp_t;

  typedef enum logic {SPM_ST_ITEM, SPM_ST_DATA} spm_state_t;

endpackage : spm_pkg

/* File: spm_key_filter.sv */
/*
  spm_key_filter: debounces the panel keys and emits one pulse per press.
  assumes key inputs are synchronous to clock_i and high while pressed.
*/
`timescale 1ns/1ps
module spm_key_filter #(
  parameter int DEB_CYC = spm_pkg::SPM_DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // keys
  input wire spm_pkg::spm_keys_t raw_i,
  output spm_pkg::spm_keys_t press_o
);
  import spm_pkg::*;

  logic [SPM_KEYS-1:0] raw;
  logic [SPM_KEYS-1:0] press;
  assign raw = raw_i;
  assign press_o = press;

  // ----------------------------------------
  // one filter per key
  // ----------------------------------------
  for (genvar k = 0; k < SPM_KEYS; k++)
  begin : g_key
    logic stable;
    logic hit;
    logic [SPM_DEB_W-1:0] cnt;
    assign press[k] = hit;
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
      if (sys_rst_i)
      begin
        stable <= 1'b0;
        cnt <= '0;
        hit <= 1'b0;
      end
      else
      begin
        hit <= 1'b0;
        if (raw[k] == stable)
        begin
          cnt <= '0;
        end
        else if (cnt >= SPM_DEB_W'(DEB_CYC - 1))
        begin
          cnt <= '0;
          stable <= raw[k];
          hit <= raw[k];
        end
        else
        begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end

endmodule : spm_key_filter

/* File: spm_monitor.sv */
/*
  spm_monitor: panel monitor for a two-axis drive; key handling, axis select,
  counter paging and segment patterns for terminal and encoder levels.
  assumes the keys and axis signals are synchronous to clock_i; purely observes the drive.
*/
// Functional notes
// - each input position lights its upper segment when open and its lower segment when closed.
// - each output position lights its upper segment when off and its lower segment when conducting.
// - the decimal point of the rightmost digit is lit for axis B and dark for axis A.
// - the input view shows eight positions, position n following input terminal n.
// - the output view shows six positions, position n following output terminal n.
// - for an incremental encoder the encoder view maps positions 1..8 to W, V, U, motor line break, C, B, A, encoder line break; otherwise it shows dashes.
// - in item view the up and down keys step the item number, chosen before its data is asked for.
// - the set key on an item shows its data for axis A with the axis point dark.
// - up or down while data is shown switches to the other axis.
// - the set key while data is shown returns to the item number.
// - the first data view of a wide counter shows its lowest four digits.
// - the first shift press on a wide counter shows its middle four digits.
// - the second shift shows the top two digits and a further shift wraps to the lowest four.
// - the command pulse counter is 32 bits, shown in hex, counting only in position mode.
// - the monitor may be used while the motor runs and never acts on the drive.
`timescale 1ns/1ps
module spm_monitor #(
  parameter int DEB_CYC = spm_pkg::SPM_DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // panel keys
  input wire spm_pkg::spm_keys_t keys_i,
  // observed axis signals
  input wire spm_pkg::spm_axis_t axis_a_i,
  input wire spm_pkg::spm_axis_t axis_b_i,
  // panel display
  output spm_pkg::spm_disp_t disp_o,
  output logic [spm_pkg::SPM_ITEM_W-1:0] item_o,
  output logic data_view_o
);
  import spm_pkg::*;

  // ----------------------------------------
  // decoding helpers
  // ----------------------------------------
  function automatic logic [7:0] level_seg(input logic active);
    logic [7:0] s;
    s = SPM_SEG_BLANK;
    if (active)
      s[SPM_SEG_LOWER] = 1'b1;
    else
      s[SPM_SEG_UPPER] = 1'b1;
    return s;
  endfunction : level_seg

  function automatic logic [7:0] hex_seg(input logic [3:0] v);
    logic [7:0] s;
    s = SPM_SEG_BLANK;
    case (v)
      4'h0: s = 8'h3f;
      4'h1: s = 8'h06;
      4'h2: s = 8'h5b;
      4'h3: s = 8'h4f;
      4'h4: s = 8'h66;
      4'h5: s = 8'h6d;
      4'h6: s = 8'h7d;
      4'h7: s = 8'h07;
      4'h8: s = 8'h7f;
      4'h9: s = 8'h6f;
      4'ha: s = 8'h77;
      4'hb: s = 8'h7c;
      4'hc: s = 8'h39;
      4'hd: s = 8'h5e;
      4'he: s = 8'h79;
      default: s = 8'h71;
    endcase
    return s;
  endfunction : hex_seg

  // ----------------------------------------
  // key filter
  // ----------------------------------------
  spm_keys_t press;
  spm_key_filter #(
    .DEB_CYC(DEB_CYC)
  ) u_keys (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .raw_i(keys_i),
    .press_o(press)
  );

  logic key_set;
  logic key_updn;
  logic key_up;
  logic key_down;
  logic key_shift;
  assign key_set = press.set;
  assign key_updn = !press.set && (press.up || press.down);
  assign key_up = !press.set && press.up;
  assign key_down = !press.set && !press.up && press.down;
  assign key_shift = !press.set && !press.up && !press.down && press.shift;

  // ----------------------------------------
  // command pulse counters
  // ----------------------------------------
  spm_axis_t ax [SPM_AXES];
  assign ax[0] = axis_a_i;
  assign ax[1] = axis_b_i;
  logic [SPM_CNT_W-1:0] cmd_cnt [SPM_AXES];

  for (genvar a = 0; a < SPM_AXES; a++)
  begin : g_cnt
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
      if (sys_rst_i)
        cmd_cnt[a] <= '0;
      else if (ax[a].pos_mode && ax[a].cmd_pulse)
        cmd_cnt[a] <= cmd_cnt[a] + 1'b1;
    end
  end

  // ----------------------------------------
  // view state
  // ----------------------------------------
  spm_state_t state;
  logic [SPM_ITEM_W-1:0] item;
  logic axis;
  logic [1:0] page;

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      state <= SPM_ST_ITEM;
    else if (key_set)
      state <= (state == SPM_ST_ITEM) ? SPM_ST_DATA : SPM_ST_ITEM;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      item <= SPM_ITEM_SPEED;
    else if (state == SPM_ST_ITEM && key_up)
      item <= (item == SPM_ITEM_MAX) ? SPM_ITEM_SPEED : item + 1'b1;
    else if (state == SPM_ST_ITEM && key_down)
      item <= (item == SPM_ITEM_SPEED) ? SPM_ITEM_MAX : item - 1'b1;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      axis <= 1'b0;
    else if (state == SPM_ST_ITEM && key_set)
      axis <= 1'b0;
    else if (state == SPM_ST_DATA && key_updn)
      axis <= !axis;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      page <= SPM_PAGE_LOW;
    else if (key_set)
      page <= SPM_PAGE_LOW;
    else if (state == SPM_ST_DATA && item == SPM_ITEM_CMD_CNT && key_shift)
    begin
      case (page)
        SPM_PAGE_LOW: page <= SPM_PAGE_MID;
        SPM_PAGE_MID: page <= SPM_PAGE_TOP;
        default: page <= SPM_PAGE_LOW;
      endcase
    end
  end

  // ----------------------------------------
  // display pattern, rebuilt every cycle
  // ----------------------------------------
  spm_disp_t next_disp;
  spm_axis_t sel;
  logic [SPM_CNT_W+SPM_CNT_W/4-1:0] cnt_ext;
  assign sel = ax[axis];
  assign cnt_ext = {8'h00, cmd_cnt[axis]};

  always_comb
  begin
    next_disp = '{default: SPM_SEG_BLANK};
    case (state)
      SPM_ST_ITEM:
      begin
        next_disp[SPM_DIG_U] = SPM_SEG_U;
        next_disp[SPM_DIG_N] = SPM_SEG_N;
        next_disp[2] = hex_seg(4'h0);
        if (item >= SPM_ITEM_TEN)
        begin
          next_disp[1] = hex_seg(4'h1);
          next_disp[0] = hex_seg(4'(item - SPM_ITEM_TEN));
        end
        else
        begin
          next_disp[1] = hex_seg(4'h0);
          next_disp[0] = hex_seg(item[3:0]);
        end
      end
      SPM_ST_DATA:
      begin
        case (item)
          SPM_ITEM_IN:
            for (int n = 0; n < SPM_IN_TERMS; n++)
              next_disp[n] = level_seg(!sel.in_level[n]);
          SPM_ITEM_OUT:
            for (int n = 0; n < SPM_OUT_TERMS; n++)
              next_disp[n] = level_seg(sel.out_on[n]);
          SPM_ITEM_ENC:
            if (sel.incr_enc)
            begin
              next_disp[0] = level_seg(sel.enc_phase_w);
              next_disp[1] = level_seg(sel.enc_phase_v);
              next_disp[2] = level_seg(sel.enc_phase_u);
              next_disp[3] = level_seg(sel.uvw_brk);
              next_disp[4] = level_seg(sel.enc_phase_c);
              next_disp[5] = level_seg(sel.enc_phase_b);
              next_disp[6] = level_seg(sel.enc_phase_a);
              next_disp[7] = level_seg(sel.abc_brk);
            end
            else
              next_disp = '{default: SPM_SEG_DASH};
          SPM_ITEM_CMD_CNT:
            case (page)
              SPM_PAGE_LOW:
                for (int d = 0; d < SPM_PAGE_DIGITS; d++)
                  next_disp[d] = hex_seg(cnt_ext[SPM_PAGE_LOW_LSB + 4*d +: 4]);
              SPM_PAGE_MID:
                for (int d = 0; d < SPM_PAGE_DIGITS; d++)
                  next_disp[d] = hex_seg(cnt_ext[SPM_PAGE_MID_LSB + 4*d +: 4]);
              default:
                for (int d = 0; d < SPM_TOP_DIGITS; d++)
                  next_disp[d] = hex_seg(cnt_ext[SPM_PAGE_TOP_LSB + 4*d +: 4]);
            endcase
          default:
            next_disp = '{default: SPM_SEG_DASH};
        endcase
        next_disp[SPM_DIG_AXIS][SPM_SEG_DP] = axis;
      end
      default:
        next_disp = '{default: SPM_SEG_BLANK};
    endcase
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      disp_o <= '{default: SPM_SEG_BLANK};
      item_o <= '0;
      data_view_o <= 1'b0;
    end
    else
    begin
      disp_o <= next_disp;
      item_o <= item;
      data_view_o <= (state == SPM_ST_DATA);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_set_on_item;
    state == SPM_ST_ITEM && key_set;
  endsequence

  sequence s_first_view;
    state == SPM_ST_DATA && axis == 1'b0 && page == SPM_PAGE_LOW ##1 data_view_o && !disp_o[0][SPM_SEG_DP];
  endsequence

  AST_SET_SHOWS_A: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_set_on_item |=> s_first_view) else $error("set did not open axis A data");

  AST_SET_RETURNS: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    state == SPM_ST_DATA && key_set |=> state == SPM_ST_ITEM ##1 !data_view_o)
    else $error("set did not return to item view");

  AST_AXIS_SWAP: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    state == SPM_ST_DATA && key_updn |=> axis != $past(axis) && item == $past(item))
    else $error("up or down did not swap axis");

  AST_ITEM_UP: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    state == SPM_ST_ITEM && key_up && item != SPM_ITEM_MAX |=> item == $past(item) + 1'b1)
    else $error("item did not step up");

  AST_PAGE_WALK: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    state == SPM_ST_DATA && item == SPM_ITEM_CMD_CNT && key_shift && page == SPM_PAGE_TOP
    |=> page == SPM_PAGE_LOW) else $error("shift did not wrap to low digits");

  AST_CNT_HOLD: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !axis_a_i.pos_mode |=> cmd_cnt[0] == $past(cmd_cnt[0])) else $error("counter moved outside position mode");

  AST_DP_AXIS: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    state == SPM_ST_DATA |=> disp_o[SPM_DIG_AXIS][SPM_SEG_DP] == $past(axis)) else $error("axis point wrong");

  AST_IN_SEG: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    state == SPM_ST_DATA && item == SPM_ITEM_IN && axis == 1'b0
    |=> disp_o[7][SPM_SEG_UPPER] == $past(axis_a_i.in_level[7]) && disp_o[7][SPM_SEG_LOWER] != disp_o[7][SPM_SEG_UPPER])
    else $error("input segment wrong");

  AST_OUT_BLANK: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    state == SPM_ST_DATA && item == SPM_ITEM_OUT |=> disp_o[7] == SPM_SEG_BLANK && disp_o[6] == SPM_SEG_BLANK)
    else $error("unused output positions lit");

endmodule : spm_monitor

/* File: spm_panel_model.sv */
/*
  spm_panel_model: front panel key model for the panel signal monitor.
  assumes keys are sampled on clock_i and are high while pressed; the
  segment display side is observed directly by the bench.
*/
`timescale 1ns/1ps
module spm_panel_model #(
  parameter int DEB_CYC = 4
) (
  // clock
  input wire logic clock_i,
  // keys toward the monitor
  output spm_pkg::spm_keys_t keys_o
);
  import spm_pkg::*;

  initial keys_o = '0;

  // ----------------------------------------
  // one key held, released, then a settle gap
  // ----------------------------------------
  task automatic tap(input int k, input int hold);
    @(negedge clock_i);
    keys_o[k] = 1'b1;
    repeat (hold) @(negedge clock_i);
    keys_o[k] = 1'b0;
    repeat (2 * DEB_CYC + 4) @(negedge clock_i);
  endtask : tap

endmodule : spm_panel_model

/* File: test_servo_panel_signal_monitor.sv */
/*
  test_servo_panel_signal_monitor: self-checking bench for spm_monitor.
  assumes the panel model drives the keys and the bench drives both axes
  at the falling edge of a 250 MHz clock.
*/
`timescale 1ns/1ps
`define SPM_CHECK(got, exp) check_value(64'(got), 64'(exp))
module test_servo_panel_signal_monitor;
  import spm_pkg::*;

  localparam int DEB = 4;
  localparam int K_UP = 0;
  localparam int K_DOWN = 1;
  localparam int K_SET = 2;
  localparam int K_SHIFT = 3;

  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  spm_keys_t keys;
  spm_axis_t axis_a = '0;
  spm_axis_t axis_b = '0;
  spm_disp_t disp;
  logic [SPM_ITEM_W-1:0] item;
  logic data_view;
  // plain a..g patterns of the digits 0, 1 and b
  localparam logic [7:0] SEG_ZERO = 8'h3f;
  localparam logic [7:0] SEG_ONE = 8'h06;
  localparam logic [7:0] SEG_B = 8'h7c;
  int errors = 0;
  int checks_done = 0;

  always #2 clock_i = ~clock_i;

  spm_panel_model #(.DEB_CYC(DEB)) panel (.clock_i(clock_i), .keys_o(keys));

  spm_monitor #(.DEB_CYC(DEB)) dut (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .keys_i(keys),
    .axis_a_i(axis_a),
    .axis_b_i(axis_b),
    .disp_o(disp),
    .item_o(item),
    .data_view_o(data_view)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic check_value(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_value

  task automatic press(input int k);
    panel.tap(k, 3 * DEB);
  endtask : press

  task automatic settle;
    repeat (3) @(negedge clock_i);
  endtask : settle

  task automatic check_levels(input logic [7:0] lvl, input logic axis_sel);
    for (int d = 0; d < SPM_IN_TERMS; d++)
    begin
      `SPM_CHECK(disp[d][SPM_SEG_LOWER], !lvl[d]);
      `SPM_CHECK(disp[d][SPM_SEG_UPPER], lvl[d]);
    end
    `SPM_CHECK(disp[SPM_DIG_AXIS][SPM_SEG_DP], axis_sel);
  endtask : check_levels

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_item_step;
    `SPM_CHECK(item, SPM_ITEM_SPEED);
    `SPM_CHECK(disp[SPM_DIG_U], SPM_SEG_U);
    `SPM_CHECK(disp[SPM_DIG_N], SPM_SEG_N);
    `SPM_CHECK(disp[0], SEG_ZERO);
    press(K_DOWN);
    `SPM_CHECK(item, SPM_ITEM_MAX);
    `SPM_CHECK(disp[1], SEG_ONE);
    press(K_UP);
    `SPM_CHECK(item, SPM_ITEM_SPEED);
    panel.tap(K_UP, DEB - 2);
    `SPM_CHECK(item, SPM_ITEM_SPEED);
    for (int i = 0; i < 7; i++)
      press(K_UP);
    `SPM_CHECK(item, SPM_ITEM_IN);
    `SPM_CHECK(data_view, 1'b0);
  endtask : t_item_step

  task automatic t_inputs;
    axis_a.in_level = 8'ha5;
    axis_b.in_level = 8'h3c;
    press(K_SET);
    `SPM_CHECK(data_view, 1'b1);
    check_levels(8'ha5, 1'b0);
    axis_a.in_level = 8'h0f;
    settle();
    check_levels(8'h0f, 1'b0);
    press(K_UP);
    check_levels(8'h3c, 1'b1);
    press(K_DOWN);
    check_levels(8'h0f, 1'b0);
    press(K_SET);
    `SPM_CHECK(data_view, 1'b0);
    `SPM_CHECK(item, SPM_ITEM_IN);
  endtask : t_inputs

  task automatic t_outputs;
    press(K_UP);
    axis_a.out_on = 6'h2d;
    press(K_SET);
    `SPM_CHECK(item, SPM_ITEM_OUT);
    for (int d = 0; d < SPM_OUT_TERMS; d++)
    begin
      `SPM_CHECK(disp[d][SPM_SEG_LOWER], axis_a.out_on[d]);
      `SPM_CHECK(disp[d][SPM_SEG_UPPER], !axis_a.out_on[d]);
    end
    `SPM_CHECK(disp[6], SPM_SEG_BLANK);
    `SPM_CHECK(disp[7], SPM_SEG_BLANK);
    press(K_SET);
  endtask : t_outputs

  task automatic t_encoder;
    logic [7:0] exp_low;
    press(K_UP);
    axis_a.incr_enc = 1'b1;
    axis_a.enc_phase_w = 1'b1;
    axis_a.uvw_brk = 1'b1;
    axis_a.enc_phase_b = 1'b1;
    axis_a.enc_phase_a = 1'b1;
    // digit 7..0: abc_brk, a, b, c, uvw_brk, u, v, w
    exp_low = 8'h69;
    press(K_SET);
    `SPM_CHECK(item, SPM_ITEM_ENC);
    for (int d = 0; d < SPM_DIGITS; d++)
      `SPM_CHECK(disp[d][SPM_SEG_LOWER], exp_low[d]);
    axis_a.incr_enc = 1'b0;
    settle();
    for (int d = 0; d < SPM_DIGITS; d++)
      `SPM_CHECK(disp[d][6:0], SPM_SEG_DASH[6:0]);
    press(K_SET);
  endtask : t_encoder

  task automatic t_counter;
    press(K_UP);
    `SPM_CHECK(item, SPM_ITEM_CMD_CNT);
    press(K_SET);
    for (int d = 0; d < SPM_PAGE_DIGITS; d++)
      `SPM_CHECK(disp[d], SEG_ZERO);
    axis_a.cmd_pulse = 1'b1;
    repeat (3) @(negedge clock_i);
    axis_a.cmd_pulse = 1'b0;
    settle();
    `SPM_CHECK(disp[0], SEG_ZERO);
    axis_a.pos_mode = 1'b1;
    axis_a.cmd_pulse = 1'b1;
    repeat (11) @(negedge clock_i);
    axis_a.cmd_pulse = 1'b0;
    settle();
    `SPM_CHECK(disp[0], SEG_B);
    `SPM_CHECK(disp[1], SEG_ZERO);
    press(K_SHIFT);
    for (int d = 0; d < SPM_PAGE_DIGITS; d++)
      `SPM_CHECK(disp[d], SEG_ZERO);
    press(K_SHIFT);
    for (int d = 0; d < SPM_TOP_DIGITS; d++)
      `SPM_CHECK(disp[d], SEG_ZERO);
    `SPM_CHECK(disp[SPM_TOP_DIGITS], SPM_SEG_BLANK);
    press(K_SHIFT);
    `SPM_CHECK(disp[0], SEG_B);
    `SPM_CHECK(disp[1], SEG_ZERO);
    press(K_UP);
    `SPM_CHECK(disp[0][SPM_SEG_DP], 1'b1);
    `SPM_CHECK(disp[0][6:0], SEG_ZERO[6:0]);
    press(K_SET);
    `SPM_CHECK(data_view, 1'b0);
  endtask : t_counter

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (16) @(negedge clock_i);
    `SPM_CHECK(disp, '0);
    sys_rst_i = 1'b0;
    settle();
    t_item_step();
    t_inputs();
    t_outputs();
    t_encoder();
    t_counter();
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge clock_i);
    errors++;
    summarize();
  end

endmodule : test_servo_panel_signal_monitor
